// ---- rwc_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the reset and watchdog block.
`ifndef RWC_CFG_SVH
`define RWC_CFG_SVH

`define RWC_IDX_WDT_CTRL    8'h31
`define RWC_IDX_SUPPLY      8'h34
`define RWC_IDX_CAUSE       8'h3B
`define RWC_IDX_PROTECT     8'h3C

`define RWC_WDT_IF_BIT      7
`define RWC_WDT_IE_BIT      6
`define RWC_WDT_P3_BIT      5
`define RWC_WDT_RE_BIT      3
`define RWC_SUP_F_BIT       7
`define RWC_SUP_IE_BIT      6
`define RWC_CAUSE_WD_BIT    3
`define RWC_CAUSE_EXT_BIT   1
`define RWC_CAUSE_POR_BIT   0

`define RWC_SIGNATURE       8'hD8
`define RWC_PROTECT_CYCLES  3'h4
`define RWC_PRESCALE_BASE   21'h000800
`define RWC_PRESCALE_MAX    4'h9
`define RWC_SUP_OFF         3'h0
`define RWC_SUP_RST_LO      3'h1
`define RWC_SUP_RST_HI      3'h2
`define RWC_SUP_FLAG_LO     3'h3
`define RWC_SUP_FLAG_HI     3'h4

`define RWC_STRETCH_DEF     64
`define RWC_EXT_PULSE_DEF   4
`define RWC_CAUSE_RESET     1'h1

`endif

// ---- rwc_pkg.sv ----
// Types shared by the reset and watchdog block.
package rwc_pkg;

    typedef enum logic [1:0] {
        RWC_HOLD,
        RWC_PULSE,
        RWC_STRETCH,
        RWC_RUN
    } rwc_rst_e;

    typedef struct packed {
        logic por;
        logic ext_n;
        logic below;
        logic osc;
        logic always_on;
        logic pin_off;
    } rwc_pins_s;

    typedef struct packed {
        rwc_pins_s   sync1;
        rwc_pins_s   sync2;
        logic        osc_prev;
        rwc_rst_e    rst_state;
        logic [15:0] stretch_cnt;
        logic [7:0]  ext_cnt;
        logic        sys_rst_n;
        logic        fetch;
        logic [19:0] wdt_cnt;
        logic        wdif;
        logic        watchdog_irq_enable;
        logic        watchdog_reset_enable;
        logic [3:0]  watchdog_prescale_select;
        logic        supply_low_flag;
        logic        supply_low_irq_enable;
        logic [2:0]  supply_monitor;
        logic        watchdog_cause_flag;
        logic        extrf;
        logic        power_on_cause_flag;
        logic        por_prev;
        logic [2:0]  ccp_cnt;
        logic [31:0] rdata;
    } rwc_state_s;

endpackage

// ---- rwc_top.sv ----
// Reset combiner, reset stretcher, watchdog and supply monitor with an APB register slave.
//
// Notes on behaviour
// - Internal reset returns watchdog control registers to initial values (supply ones only on power-on); release pulses vector fetch.
// - Port reset output asserts combinationally from any raw reset source.
// - After all sources clear, a stretch counter holds internal reset before release.
// - Power-on, reset pin, supply monitor and watchdog combine into one reset.
// - Power-on detection reasserts reset at once, with no stretch.
// - Pin held low for the minimum width resets; release waits for the stretch.
// - The pin-disable fuse blocks the reset pin path entirely.
// - Watchdog reset is a one-cycle pulse; stretching starts right after it.
// - Watchdog counts edges of its own oscillator; prescaler picks the timeout.
// - Watchdog counter clears on restart, when stopped, and on any reset.
// - Ten timeout periods; expiry in reset mode resets the device.
// - Watchdog may interrupt instead; that interrupt drives the wake request.
// - Always-on fuse picks safety level two, otherwise level one.
// - Level one: plain enable, disable only inside the protected window.
// - Level two: enable reads one, prescaler changes only inside the window.
// - Only the signature byte opens the four-cycle protected window.
// - Supply low flag sets while below level; enabled flag raises interrupt.
// - Flag clears when supply is back above, level is not a flag code, or on power-on; writes do not clear it.
// - Supply monitor in reset codes holds reset, release runs the stretch.
// - Power-on cause flag sets once the power-on condition ends.
// - Prescaler code n gives 2048 shifted left n cycles; codes above nine reserved.
// - Mode follows enable bits; combined mode interrupts first, then resets.
// - Watchdog cause flag forces the reset enable bit to read one.
// - Level codes: off, two reset codes, two flag codes, rest not allowed.
`timescale 1ns/100ps
`default_nettype none
`include "rwc_cfg.svh"

module rwc_top
    import rwc_pkg::*;
#(
    parameter int STRETCH_CYCLES = `RWC_STRETCH_DEF,
    parameter int EXT_MIN_PULSE  = `RWC_EXT_PULSE_DEF
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        por_detect,
    input  wire logic        ext_reset_n,
    input  wire logic        supply_below,
    input  wire logic        wdt_osc,
    input  wire logic        watchdog_always_on_fuse,
    input  wire logic        reset_pin_disable_fuse,
    input  wire logic        wdt_restart,
    input  wire logic        wdt_vector_taken,
    output logic             system_reset_n,
    output logic             io_reset_n,
    output logic             fetch_from_vector,
    output logic [2:0]       supply_level_select,
    output logic             wdt_irq,
    output logic             supply_irq,
    output logic             wake_request
);

    localparam logic [15:0] STRETCH_LAST = 16'(STRETCH_CYCLES - 1);
    localparam logic [7:0]  EXT_LAST     = 8'(EXT_MIN_PULSE);

    rwc_state_s r;
    rwc_state_s n;

    function automatic logic [7:0] byte_addr(input logic [7:0] idx);
        byte_addr = {idx[5:0], 2'b00};
    endfunction

    function automatic logic sup_reset_code(input logic [2:0] code);
        sup_reset_code = (code == `RWC_SUP_RST_LO) || (code == `RWC_SUP_RST_HI);
    endfunction

    function automatic logic sup_flag_code(input logic [2:0] code);
        sup_flag_code = (code == `RWC_SUP_FLAG_LO) || (code == `RWC_SUP_FLAG_HI);
    endfunction

    function automatic logic [19:0] wdt_limit(input logic [3:0] code);
        logic [20:0] span;
        span = `RWC_PRESCALE_BASE << code;
        wdt_limit = 20'(span - 21'h000001);
    endfunction

    rwc_pins_s pins;
    rwc_pins_s s;
    logic      level_two;
    logic      ext_active;
    logic      src;
    logic      wde_eff;
    logic      irq_mode;
    logic      running;
    logic      tick;
    logic      timeout;
    logic      wdt_reset_evt;
    logic      wdt_irq_evt;
    logic      in_reset;
    logic      wr;
    logic      setup;
    logic      window_open;
    logic      hit_wdt;
    logic      hit_sup;
    logic      hit_cause;
    logic      hit_prot;
    logic [3:0] new_wdp;
    logic [31:0] rd_mux;

    always_comb begin
        pins = '{por: por_detect, ext_n: ext_reset_n, below: supply_below, osc: wdt_osc,
                 always_on: watchdog_always_on_fuse, pin_off: reset_pin_disable_fuse};
        s           = r.sync2;
        level_two   = s.always_on;
        ext_active  = (r.ext_cnt == EXT_LAST);
        src         = s.por | ext_active | (s.below & sup_reset_code(r.supply_monitor));
        wde_eff     = r.watchdog_reset_enable | r.watchdog_cause_flag | level_two;
        irq_mode    = r.watchdog_irq_enable & ~level_two;
        running     = wde_eff | irq_mode;
        tick        = s.osc & ~r.osc_prev;
        timeout     = running & tick & (r.wdt_cnt == wdt_limit(r.watchdog_prescale_select)) & r.sys_rst_n;
        wdt_irq_evt = timeout & irq_mode & ~r.wdif;
        wdt_reset_evt = timeout & wde_eff & ~wdt_irq_evt;
        in_reset    = ~r.sys_rst_n;
        setup       = psel & ~penable;
        wr          = psel & penable & pwrite;
        hit_wdt     = (paddr == byte_addr(`RWC_IDX_WDT_CTRL));
        hit_sup     = (paddr == byte_addr(`RWC_IDX_SUPPLY));
        hit_cause   = (paddr == byte_addr(`RWC_IDX_CAUSE));
        hit_prot    = (paddr == byte_addr(`RWC_IDX_PROTECT));
        window_open = (r.ccp_cnt != 3'h0);
        new_wdp     = {pwdata[`RWC_WDT_P3_BIT], pwdata[2:0]};
        rd_mux      = '0;
        if (hit_wdt) begin
            rd_mux[`RWC_WDT_IF_BIT] = r.wdif;
            rd_mux[`RWC_WDT_IE_BIT] = r.watchdog_irq_enable;
            rd_mux[`RWC_WDT_P3_BIT] = r.watchdog_prescale_select[3];
            rd_mux[`RWC_WDT_RE_BIT] = wde_eff;
            rd_mux[2:0]             = r.watchdog_prescale_select[2:0];
        end else if (hit_sup) begin
            rd_mux[`RWC_SUP_F_BIT]  = r.supply_low_flag;
            rd_mux[`RWC_SUP_IE_BIT] = r.supply_low_irq_enable;
            rd_mux[2:0]             = r.supply_monitor;
        end else if (hit_cause) begin
            rd_mux[`RWC_CAUSE_WD_BIT]  = r.watchdog_cause_flag;
            rd_mux[`RWC_CAUSE_EXT_BIT] = r.extrf;
            rd_mux[`RWC_CAUSE_POR_BIT] = r.power_on_cause_flag;
        end
    end

    always_comb begin
        n          = r;
        n.sync1    = pins;
        n.sync2    = r.sync1;
        n.osc_prev = s.osc;
        n.fetch    = 1'b0;
        n.por_prev = s.por;
        if (setup) begin
            n.rdata = rd_mux;
        end

        if (~s.ext_n & ~s.pin_off) begin
            if (r.ext_cnt != EXT_LAST) begin
                n.ext_cnt = r.ext_cnt + 8'h01;
            end
        end else begin
            n.ext_cnt = 8'h00;
        end

        unique case (r.rst_state)
            RWC_HOLD: begin
                n.sys_rst_n = 1'b0;
                if (!src) begin
                    n.rst_state   = RWC_STRETCH;
                    n.stretch_cnt = 16'h0000;
                end
            end
            RWC_PULSE: begin
                n.sys_rst_n   = 1'b0;
                n.stretch_cnt = 16'h0000;
                n.rst_state   = src ? RWC_HOLD : RWC_STRETCH;
            end
            RWC_STRETCH: begin
                if (src) begin
                    n.rst_state = RWC_HOLD;
                end else if (r.stretch_cnt == STRETCH_LAST) begin
                    n.rst_state = RWC_RUN;
                    n.sys_rst_n = 1'b1;
                    n.fetch     = 1'b1;
                end else begin
                    n.stretch_cnt = r.stretch_cnt + 16'h0001;
                end
            end
            RWC_RUN: begin
                if (src) begin
                    n.rst_state = RWC_HOLD;
                    n.sys_rst_n = 1'b0;
                end else if (wdt_reset_evt) begin
                    n.rst_state = RWC_PULSE;
                    n.sys_rst_n = 1'b0;
                end
            end
        endcase

        if (r.ccp_cnt != 3'h0) begin
            n.ccp_cnt = r.ccp_cnt - 3'h1;
        end
        if (wr && hit_prot) begin
            n.ccp_cnt = (pwdata[7:0] == `RWC_SIGNATURE) ? `RWC_PROTECT_CYCLES : 3'h0;
        end

        if (wr && hit_wdt) begin
            n.ccp_cnt = 3'h0;
            n.watchdog_irq_enable    = pwdata[`RWC_WDT_IE_BIT];
            if (pwdata[`RWC_WDT_IF_BIT]) begin
                n.wdif = 1'b0;
            end
            if (!level_two) begin
                if (new_wdp <= `RWC_PRESCALE_MAX) begin
                    n.watchdog_prescale_select = new_wdp;
                end
                if (pwdata[`RWC_WDT_RE_BIT]) begin
                    n.watchdog_reset_enable = 1'b1;
                end else if (window_open && !r.watchdog_cause_flag) begin
                    n.watchdog_reset_enable = 1'b0;
                end
            end else if (window_open && new_wdp <= `RWC_PRESCALE_MAX) begin
                n.watchdog_prescale_select = new_wdp;
            end
        end
        if (wdt_vector_taken) begin
            n.wdif = 1'b0;
            if (wde_eff) begin
                n.watchdog_irq_enable = 1'b0;
            end
        end
        if (wdt_irq_evt) begin
            n.wdif = 1'b1;
        end

        if (in_reset || !running || wdt_restart || timeout) begin
            n.wdt_cnt = 20'h00000;
        end else if (tick) begin
            n.wdt_cnt = r.wdt_cnt + 20'h00001;
        end
        if (in_reset) begin
            n.wdif    = 1'b0;
            n.watchdog_irq_enable    = 1'b0;
            n.watchdog_reset_enable     = 1'b0;
            n.watchdog_prescale_select     = 4'h0;
            n.ccp_cnt = 3'h0;
        end
        if (r.watchdog_cause_flag) begin
            n.watchdog_reset_enable = 1'b1;
        end

        if (wr && hit_sup) begin
            n.supply_low_irq_enable = pwdata[`RWC_SUP_IE_BIT];
            if (pwdata[2:0] <= `RWC_SUP_FLAG_HI) begin
                n.supply_monitor = pwdata[2:0];
                if (pwdata[2:0] != r.supply_monitor) begin
                    n.supply_low_flag = 1'b0;
                end
            end
            if (!pwdata[`RWC_SUP_F_BIT]) begin
                n.supply_low_flag = 1'b0;
            end
        end
        if (!s.below || !sup_flag_code(r.supply_monitor)) begin
            n.supply_low_flag = 1'b0;
        end else begin
            n.supply_low_flag = 1'b1;
        end
        if (s.por) begin
            n.supply_monitor   = `RWC_SUP_OFF;
            n.supply_low_irq_enable = 1'b0;
            n.supply_low_flag  = 1'b0;
        end

        if (wr && hit_cause) begin
            n.watchdog_cause_flag  = r.watchdog_cause_flag & pwdata[`RWC_CAUSE_WD_BIT];
            n.extrf = r.extrf & pwdata[`RWC_CAUSE_EXT_BIT];
            n.power_on_cause_flag  = r.power_on_cause_flag & pwdata[`RWC_CAUSE_POR_BIT];
        end
        if (wdt_reset_evt && r.rst_state == RWC_RUN && !src) begin
            n.watchdog_cause_flag = 1'b1;
        end
        if (ext_active) begin
            n.extrf = 1'b1;
        end
        if (s.por) begin
            n.watchdog_cause_flag  = 1'b0;
            n.extrf = 1'b0;
        end
        if (r.por_prev && !s.por) begin
            n.power_on_cause_flag = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r             <= '0;
            r.sync1.ext_n <= 1'b1;
            r.sync2.ext_n <= 1'b1;
            r.rst_state   <= RWC_HOLD;
            r.power_on_cause_flag        <= `RWC_CAUSE_RESET;
        end else begin
            r <= n;
        end
    end

    // Port reset is combinational so that it acts with no clock running.
    assign io_reset_n = ~(por_detect | (~ext_reset_n & ~reset_pin_disable_fuse)
                        | (supply_below & sup_reset_code(r.supply_monitor))) & r.sys_rst_n;
    assign system_reset_n      = r.sys_rst_n;
    assign fetch_from_vector   = r.fetch;
    assign supply_level_select = r.supply_monitor;
    assign wdt_irq             = r.wdif & r.watchdog_irq_enable & ~level_two;
    assign supply_irq          = r.supply_low_flag & r.supply_low_irq_enable;
    assign wake_request        = wdt_irq;
    assign prdata              = r.rdata;
    assign pready              = 1'b1;
    assign pslverr             = psel & penable & ~(hit_wdt | hit_sup | hit_cause | hit_prot);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_io_async;
        por_detect |-> !io_reset_n;
    endproperty
    a_io_async: assert property (p_io_async) else $error("Port reset missed power-on source.");

    property p_stretch;
        $rose(r.sys_rst_n) |-> $past(r.rst_state) == RWC_STRETCH && r.fetch;
    endproperty
    a_stretch: assert property (p_stretch) else $error("Release without stretch or fetch.");

    property p_por_now;
        (r.sync2.por && r.rst_state == RWC_RUN) |=> !r.sys_rst_n;
    endproperty
    a_por_now: assert property (p_por_now) else $error("Power-on reset was delayed.");

    property p_pin_off;
        r.sync2.pin_off && r.sync1.pin_off |=> !ext_active;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("Disabled pin still resets.");

    property p_wdt_pulse;
        (r.rst_state == RWC_RUN && wdt_reset_evt && !src)
            |=> !r.sys_rst_n && r.rst_state == RWC_PULSE ##1 r.rst_state != RWC_PULSE;
    endproperty
    a_wdt_pulse: assert property (p_wdt_pulse) else $error("Watchdog pulse not one cycle.");

    property p_wdt_clear;
        wdt_restart |=> r.wdt_cnt == 20'h00000;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear) else $error("Restart left count non-zero.");

    property p_l1_reject;
        (wr && hit_wdt && !level_two && !pwdata[`RWC_WDT_RE_BIT] && !window_open
            && r.watchdog_reset_enable && r.sys_rst_n) |=> r.watchdog_reset_enable;
    endproperty
    a_l1_reject: assert property (p_l1_reject) else $error("Unprotected disable accepted.");

    property p_l2_wdp;
        (wr && hit_wdt && level_two && !window_open && r.sys_rst_n) |=> $stable(r.watchdog_prescale_select);
    endproperty
    a_l2_wdp: assert property (p_l2_wdp) else $error("Unprotected prescale change.");

    property p_sig;
        (wr && hit_prot && pwdata[7:0] == `RWC_SIGNATURE && r.sys_rst_n)
            |=> r.ccp_cnt == `RWC_PROTECT_CYCLES;
    endproperty
    a_sig: assert property (p_sig) else $error("Signature did not open window.");

    property p_watchdog_cause_flag_force;
        r.watchdog_cause_flag |=> r.watchdog_reset_enable;
    endproperty
    a_watchdog_cause_flag_force: assert property (p_watchdog_cause_flag_force) else $error("Enable not forced by cause.");

    property p_flag_clear;
        !r.sync2.below |=> !r.supply_low_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("Low flag stayed with supply up.");

    c_wdt_reset: cover property (r.rst_state == RWC_PULSE);
    c_wdt_irq: cover property (wdt_irq_evt);
    c_supply_flag: cover property ($rose(r.supply_low_flag));
    c_ext_reset: cover property ($rose(ext_active));

endmodule

`default_nettype wire

// ---- rwc_core_model.sv ----
// Behavioural model of the processor core side and the watchdog oscillator.
`timescale 1ns/100ps
`default_nettype none

module rwc_core_model (
    input  wire logic pclk,
    input  wire logic wdt_irq,
    input  wire logic ack_en,
    input  wire logic kick_en,
    output logic      wdt_osc,
    output logic      wdt_restart,
    output logic      wdt_vector_taken
);
    logic [9:0] kick_cnt;

    initial begin
        kick_cnt = 10'h000;
        wdt_osc = 1'h0;
        wdt_restart = 1'h0;
        wdt_vector_taken = 1'h0;
    end

    // The oscillator toggles every bus clock, giving one rising edge per two bus clocks, so that timeouts stay short.
    always @(posedge pclk) begin
        wdt_osc <= ~wdt_osc;
        kick_cnt <= kick_cnt + 10'h001;
        wdt_restart <= kick_en && kick_cnt == 10'h3FF;
        wdt_vector_taken <= ack_en && wdt_irq && !wdt_vector_taken;
    end
endmodule
`default_nettype wire

// ---- test_reset_and_watchdog_control.sv ----
// Self-checking bench of the reset and watchdog block.
`timescale 1ns/100ps
`default_nettype none
`include "rwc_cfg.svh"

module test_reset_and_watchdog_control;
    localparam int         STRETCH = 8;
    localparam logic [7:0] A_CTRL  = 8'(`RWC_IDX_WDT_CTRL << 2);
    localparam logic [7:0] A_SUP   = 8'(`RWC_IDX_SUPPLY << 2);
    localparam logic [7:0] A_CAUSE = 8'(`RWC_IDX_CAUSE << 2);
    localparam logic [7:0] A_PROT  = 8'(`RWC_IDX_PROTECT << 2);
    logic        pclk     = 1'h0;
    logic        presetn  = 1'h0;
    logic        psel     = 1'h0;
    logic        penable  = 1'h0;
    logic        pwrite   = 1'h0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0;
    logic        por_det  = 1'h0;
    logic        ext_n    = 1'h1;
    logic        below    = 1'h0;
    logic        fuse_on  = 1'h0;
    logic        fuse_pin = 1'h0;
    logic        ack_en   = 1'h0;
    logic        kick_en  = 1'h0;
    logic [31:0] prdata, rd;
    logic [2:0]  level;
    logic        pready, pslverr, err, osc, restart, taken;
    logic        system_reset_n, io_reset_n, fetch, wdt_irq, supply_irq, wake;
    int          fails    = 0;
    int          compares = 0;

    rwc_top #(.STRETCH_CYCLES(STRETCH)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .por_detect(por_det), .ext_reset_n(ext_n), .supply_below(below), .wdt_osc(osc),
        .watchdog_always_on_fuse(fuse_on), .reset_pin_disable_fuse(fuse_pin),
        .wdt_restart(restart), .wdt_vector_taken(taken), .system_reset_n(system_reset_n),
        .io_reset_n(io_reset_n), .fetch_from_vector(fetch), .supply_level_select(level),
        .wdt_irq(wdt_irq), .supply_irq(supply_irq), .wake_request(wake));

    rwc_core_model CORE (.pclk(pclk), .wdt_irq(wdt_irq), .ack_en(ack_en), .kick_en(kick_en),
        .wdt_osc(osc), .wdt_restart(restart), .wdt_vector_taken(taken));

    always #5 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic wt(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (s !== v && n < lim);
        chk({31'h0, s}, {31'h0, v});
    endtask

    task automatic end_of_test;
        $display("Mismatches %0d, comparisons %0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #500000;
        fails++;
        end_of_test();
    end

    initial begin
        repeat (14) @(posedge pclk);
        wt(io_reset_n, 1'h0, 1);
        wt(system_reset_n, 1'h0, 1);
        @(posedge pclk);
        presetn <= 1'h1;
        wt(system_reset_n, 1'h1, STRETCH + 20);
        chk(fetch, 1'h1);
        rchk(A_CAUSE, 32'h01);
        rchk(A_CTRL, 32'h00);
        apb(1'h0, 8'h00, 32'h0);
        chk(err, 1'h1);
        apb(1'h1, A_CTRL, 32'h08);
        rchk(A_CTRL, 32'h08);
        apb(1'h1, A_CTRL, 32'h00);
        rchk(A_CTRL, 32'h08);
        apb(1'h1, A_PROT, 32'hD7);
        apb(1'h1, A_CTRL, 32'h00);
        rchk(A_CTRL, 32'h08);
        kick_en <= 1'h1;
        repeat (6000) @(posedge pclk);
        rchk(A_CAUSE, 32'h01);
        kick_en <= 1'h0;
        apb(1'h1, A_CTRL, 32'h48);
        ack_en <= 1'h1;
        wt(wdt_irq, 1'h1, 5000);
        wt(system_reset_n, 1'h0, 5000);
        wt(system_reset_n, 1'h1, STRETCH + 20);
        rchk(A_CAUSE, 32'h09);
        rchk(A_CTRL, 32'h08);
        apb(1'h1, A_CAUSE, 32'h00);
        rchk(A_CTRL, 32'h08);
        apb(1'h1, A_PROT, 32'hD8);
        apb(1'h1, A_CTRL, 32'h00);
        rchk(A_CTRL, 32'h00);
        ack_en <= 1'h0;
        apb(1'h1, A_CTRL, 32'h40);
        wt(wdt_irq, 1'h1, 5000);
        chk(wake, 1'h1);
        rchk(A_CTRL, 32'hC0);
        apb(1'h1, A_PROT, 32'hD8);
        apb(1'h1, A_CTRL, 32'h80);
        rchk(A_CTRL, 32'h00);
        ext_n <= 1'h0;
        wt(io_reset_n, 1'h0, 1);
        wt(system_reset_n, 1'h0, 20);
        @(posedge pclk);
        ext_n <= 1'h1;
        wt(system_reset_n, 1'h1, STRETCH + 20);
        rchk(A_CAUSE, 32'h02);
        fuse_pin <= 1'h1;
        repeat (4) @(posedge pclk);
        ext_n <= 1'h0;
        repeat (20) @(posedge pclk);
        chk(system_reset_n, 1'h1);
        ext_n <= 1'h1;
        fuse_pin <= 1'h0;
        apb(1'h1, A_SUP, 32'h43);
        below <= 1'h1;
        repeat (6) @(posedge pclk);
        rchk(A_SUP, 32'hC3);
        chk(supply_irq, 1'h1);
        below <= 1'h0;
        repeat (6) @(posedge pclk);
        rchk(A_SUP, 32'h43);
        apb(1'h1, A_SUP, 32'h01);
        below <= 1'h1;
        wt(system_reset_n, 1'h0, 20);
        chk(level, 32'h1);
        @(posedge pclk);
        below <= 1'h0;
        wt(system_reset_n, 1'h1, STRETCH + 20);
        apb(1'h1, A_SUP, 32'h00);
        por_det <= 1'h1;
        wt(system_reset_n, 1'h0, 10);
        @(posedge pclk);
        por_det <= 1'h0;
        wt(system_reset_n, 1'h1, STRETCH + 20);
        apb(1'h0, A_CAUSE, 32'h0);
        chk(rd & 32'h1, 32'h1);
        fuse_on <= 1'h1;
        repeat (4) @(posedge pclk);
        rchk(A_CTRL, 32'h08);
        apb(1'h1, A_CTRL, 32'h07);
        rchk(A_CTRL, 32'h08);
        apb(1'h1, A_PROT, 32'hD8);
        apb(1'h1, A_CTRL, 32'h01);
        rchk(A_CTRL, 32'h09);
        end_of_test();
    end
endmodule
`default_nettype wire
